// file: logic/tmr_params.svh
// tmr_params.svh: register offsets, field positions and reset values
// assumes: included by bare name from the timer package, the monitor and the bench
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH

`define TMR_A_T2CTL   4'h0
`define TMR_A_T2LO    4'h1
`define TMR_A_T2HI    4'h2
`define TMR_A_CRLO    4'h3
`define TMR_A_CRHI    4'h4
`define TMR_A_T01CTL  4'h5
`define TMR_A_T01MODE 4'h6
`define TMR_A_T0LO    4'h7
`define TMR_A_T0HI    4'h8
`define TMR_A_T1LO    4'h9
`define TMR_A_T1HI    4'hA
`define TMR_A_PWRCTL  4'hB

`define TMR_B_TF2   7
`define TMR_B_T2_EXTERNAL_FLAG  6
`define TMR_B_RCLK  5
`define TMR_B_UART_A_TX_CLOCK_SELECT  4
`define TMR_B_T2_EXTERNAL_ENABLE 3
`define TMR_B_TR2   2
`define TMR_B_CT2   1
`define TMR_B_CPRL2 0

`define TMR_B_TF1 3
`define TMR_B_TR1 2
`define TMR_B_TF0 1
`define TMR_B_TR0 0

`define TMR_B_M0LO  0
`define TMR_B_M0HI  1
`define TMR_B_CT0   2
`define TMR_B_GATE0 3
`define TMR_B_M1LO  4
`define TMR_B_M1HI  5
`define TMR_B_CT1   6
`define TMR_B_GATE1 7

`define TMR_B_UART_B_RX_CLOCK_SELECT 1
`define TMR_B_UART_B_TX_CLOCK_SELECT 0

`define TMR_RST8  8'h00
`define TMR_ONE8  8'h01
`define TMR_ONE16 16'h0001
`define TMR_FF8   8'hFF
`define TMR_FF16  16'hFFFF

`endif

// file: logic/tmr_pkg.sv
// tmr_pkg.sv: types shared by the timer block
// assumes: tmr_params.svh sits on the include path
`include "tmr_params.svh"
package tmr_pkg;
  typedef logic [7:0]  tmr_byte_t;
  typedef logic [3:0]  tmr_addr_t;
  typedef enum logic [1:0] {
    TMR_M_13BIT,
    TMR_M_16BIT,
    TMR_M_RELOAD8,
    TMR_M_SPLIT
  } tmr_mode_e;
endpackage : tmr_pkg

// file: logic/tmr_timers.sv
// tmr_timers.sv: timers 0/1 (reload and split modes) and timer 2
// assumes: one 200 MHz clock, core-side register port, pins are async
//
// Function
// RULE1: t0/t1 reload mode: low byte counts, reloads
// RULE2: reload mode leaves the high byte untouched
// RULE3: timer 1 in mode 3 holds count
// RULE4: t0 mode 3 low byte uses t0 controls
// RULE5: t0 high byte counts cycles, t1 run/flag
// RULE6: timer 1 mode 3 stops it, baud continues
// RULE7: t2 counts clock or count-input falling edges
// RULE8: capture mode: 16-bit up count, overflow flag
// RULE9: capture on trigger falling edge, external flag
// RULE10: auto-reload mode: rollover sets flag, reloads 16
// RULE11: trigger edge also reloads in auto-reload
// RULE12: baud mode never sets t2 overflow flag
// RULE13: baud mode ignores select, always reloads
// RULE14: baud mode trigger only sets external flag
// RULE15: t2 flags set by hardware, software clears
// RULE16: uart a rx clock: t2 or t1 overflow
// RULE17: uart a tx clock: t2 or t1 overflow
// RULE18: uart b selects held in power control
// RULE19: t2 counts only while run bit set
// RULE20: either t2 flag requests t2 interrupt
// RULE21: t0/t1 flags cleared on vector acknowledge
// RULE22: t0/t1 run gated by gate and input
// RULE23: pins synchronised, falling edge by samples
// RULE24: t2 state resets to zero
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tmr_timers
  import tmr_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire tmr_addr_t addr_i,
  input  wire tmr_byte_t wdata_i,
  input  wire logic      wr_i,
  input  wire logic      rd_i,
  output tmr_byte_t      rdata_o,
  input  wire logic      t0_external_gate_input_i,
  input  wire logic      t1_external_gate_input_i,
  input  wire logic      t0_count_input_i,
  input  wire logic      t1_count_input_i,
  input  wire logic      t2_count_input_i,
  input  wire logic      t2_trigger_input_i,
  input  wire logic      t2_irq_enable_i,
  input  wire logic      t0_vector_ack_i,
  input  wire logic      t1_vector_ack_i,
  output logic           t0_irq_o,
  output logic           t1_irq_o,
  output logic           t2_irq_o,
  output logic           uart_a_rx_clk_o,
  output logic           uart_a_tx_clk_o,
  output logic           uart_b_rx_clk_o,
  output logic           uart_b_tx_clk_o
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detect
  // 2 flops then a third sample; only stage 2 and 3 feed logic
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_s3_q;
  wire  [5:0] pin_raw = {t2_trigger_input_i, t2_count_input_i,
                         t1_count_input_i, t0_count_input_i,
                         t1_external_gate_input_i,
                         t0_external_gate_input_i};
  always_ff @(posedge clk_i) begin
    pin_s1_q <= pin_raw;           // [RULE23]
    pin_s2_q <= pin_s1_q;
    pin_s3_q <= pin_s2_q;
  end
  wire [5:0] pin_fall = pin_s3_q & ~pin_s2_q;  // [RULE23]
  wire gate0_lvl = pin_s2_q[0];
  wire gate1_lvl = pin_s2_q[1];
  wire t0_edge   = pin_fall[2];
  wire t1_edge   = pin_fall[3];
  wire t2_edge   = pin_fall[4];
  wire trig_edge = pin_fall[5];

  ////////////////////////////////////////////////////////////////////////
  // registers
  tmr_byte_t t2ctl_q;
  tmr_byte_t t2_low_byte_q;
  tmr_byte_t t2_high_byte_q;
  tmr_byte_t capture_reload_low_q;
  tmr_byte_t capture_reload_high_q;
  tmr_byte_t t01ctl_q;
  tmr_byte_t t01mode_q;
  tmr_byte_t t0_low_byte_q;
  tmr_byte_t t0_high_byte_q;
  tmr_byte_t t1_low_byte_q;
  tmr_byte_t t1_high_byte_q;
  logic [1:0] pwrctl_q;
  tmr_byte_t rdata_q;

  wire wr_t2ctl  = wr_i && addr_i == `TMR_A_T2CTL;
  wire wr_t2lo   = wr_i && addr_i == `TMR_A_T2LO;
  wire wr_t2hi   = wr_i && addr_i == `TMR_A_T2HI;
  wire wr_crlo   = wr_i && addr_i == `TMR_A_CRLO;
  wire wr_crhi   = wr_i && addr_i == `TMR_A_CRHI;
  wire wr_t01ctl = wr_i && addr_i == `TMR_A_T01CTL;
  wire wr_t01md  = wr_i && addr_i == `TMR_A_T01MODE;
  wire wr_t0lo   = wr_i && addr_i == `TMR_A_T0LO;
  wire wr_t0hi   = wr_i && addr_i == `TMR_A_T0HI;
  wire wr_t1lo   = wr_i && addr_i == `TMR_A_T1LO;
  wire wr_t1hi   = wr_i && addr_i == `TMR_A_T1HI;
  wire wr_pwr    = wr_i && addr_i == `TMR_A_PWRCTL;

  ////////////////////////////////////////////////////////////////////////
  // timers 0 and 1
  tmr_mode_e mode0;
  tmr_mode_e mode1;
  assign mode0 = tmr_mode_e'({t01mode_q[`TMR_B_M0HI], t01mode_q[`TMR_B_M0LO]});
  assign mode1 = tmr_mode_e'({t01mode_q[`TMR_B_M1HI], t01mode_q[`TMR_B_M1LO]});
  wire split0 = mode0 == TMR_M_SPLIT;
  wire tr0 = t01ctl_q[`TMR_B_TR0];
  wire tr1 = t01ctl_q[`TMR_B_TR1];
  // a counter ticks on every clock (timer) or on a pin fall (counter)
  wire tick0 = t01mode_q[`TMR_B_CT0] ? t0_edge : 1'b1;
  wire tick1 = t01mode_q[`TMR_B_CT1] ? t1_edge : 1'b1;
  wire run0  = tr0 && (!t01mode_q[`TMR_B_GATE0] || gate0_lvl); // [RULE22]
  // in split mode timer 1 loses its run bit to timer 0's high byte
  wire run1  = (split0 || tr1) &&
               (!t01mode_q[`TMR_B_GATE1] || gate1_lvl);        // [RULE22]
  wire cnt0  = run0 && tick0;                                  // [RULE4]
  wire cnt1  = run1 && tick1 && mode1 != TMR_M_SPLIT; // [RULE3] [RULE6]
  wire cnt0h = split0 && tr1;                                  // [RULE5]

  wire [15:0] t0_full  = {t0_high_byte_q, t0_low_byte_q};
  wire [15:0] t1_full  = {t1_high_byte_q, t1_low_byte_q};
  wire t0_lo_ovf  = t0_low_byte_q == `TMR_FF8;
  wire t1_lo_ovf  = t1_low_byte_q == `TMR_FF8;
  wire t0_hi_ovf  = t0_high_byte_q == `TMR_FF8;
  wire t1_hi_ovf  = t1_high_byte_q == `TMR_FF8;
  wire t0_16_ovf  = t0_full == `TMR_FF16;
  wire t1_16_ovf  = t1_full == `TMR_FF16;
  wire t0_13_ovf  = t0_hi_ovf && t0_low_byte_q[4:0] == 5'h1F;
  wire t1_13_ovf  = t1_hi_ovf && t1_low_byte_q[4:0] == 5'h1F;

  logic ovf0;
  logic ovf1;
  logic ovf0h;
  tmr_byte_t t0lo_d;
  tmr_byte_t t0hi_d;
  tmr_byte_t t1lo_d;
  tmr_byte_t t1hi_d;
  always_comb begin
    t0lo_d = t0_low_byte_q;
    t0hi_d = t0_high_byte_q;
    ovf0   = 1'b0;
    case (mode0)
      TMR_M_13BIT: if (cnt0) begin
        t0lo_d = {3'h0, t0_low_byte_q[4:0] + 5'h01};
        if (t0_low_byte_q[4:0] == 5'h1F) t0hi_d = t0_high_byte_q + `TMR_ONE8;
        ovf0 = t0_13_ovf;
      end
      TMR_M_16BIT: if (cnt0) begin
        {t0hi_d, t0lo_d} = t0_full + `TMR_ONE16;
        ovf0 = t0_16_ovf;
      end
      TMR_M_RELOAD8: if (cnt0) begin
        // high byte is never written here
        t0lo_d = t0_lo_ovf ? t0_high_byte_q                    // [RULE2]
                           : t0_low_byte_q + `TMR_ONE8;         // [RULE1]
        ovf0   = t0_lo_ovf;                                     // [RULE1]
      end
      TMR_M_SPLIT: begin
        if (cnt0) t0lo_d = t0_low_byte_q + `TMR_ONE8;           // [RULE4]
        ovf0 = cnt0 && t0_lo_ovf;                               // [RULE4]
        if (cnt0h) t0hi_d = t0_high_byte_q + `TMR_ONE8;         // [RULE5]
      end
      default: ;
    endcase
  end
  assign ovf0h = cnt0h && t0_hi_ovf;                            // [RULE5]

  always_comb begin
    t1lo_d = t1_low_byte_q;
    t1hi_d = t1_high_byte_q;
    ovf1   = 1'b0;
    if (cnt1) begin
      case (mode1)
        TMR_M_13BIT: begin
          t1lo_d = {3'h0, t1_low_byte_q[4:0] + 5'h01};
          if (t1_low_byte_q[4:0] == 5'h1F) t1hi_d = t1_high_byte_q + `TMR_ONE8;
          ovf1 = t1_13_ovf;
        end
        TMR_M_16BIT: begin
          {t1hi_d, t1lo_d} = t1_full + `TMR_ONE16;
          ovf1 = t1_16_ovf;
        end
        TMR_M_RELOAD8: begin
          t1lo_d = t1_lo_ovf ? t1_high_byte_q                   // [RULE2]
                             : t1_low_byte_q + `TMR_ONE8;        // [RULE1]
          ovf1   = t1_lo_ovf;                                    // [RULE1]
        end
        default: ;                                              // [RULE3]
      endcase
    end
  end

  // with timer 0 split, timer 1 overflow still clocks the uarts but its
  // flag belongs to timer 0's high byte
  wire tf1_set = split0 ? ovf0h : ovf1; // [RULE5] [RULE6]
  tmr_byte_t t01ctl_d;
  always_comb begin
    t01ctl_d = wr_t01ctl ? wdata_i : t01ctl_q;
    if (t0_vector_ack_i) t01ctl_d[`TMR_B_TF0] = 1'b0;           // [RULE21]
    if (t1_vector_ack_i) t01ctl_d[`TMR_B_TF1] = 1'b0;           // [RULE21]
    if (ovf0)    t01ctl_d[`TMR_B_TF0] = 1'b1;                   // [RULE21]
    if (tf1_set) t01ctl_d[`TMR_B_TF1] = 1'b1;                   // [RULE21]
  end

  ////////////////////////////////////////////////////////////////////////
  // timer 2
  wire sel_rx_a = t2ctl_q[`TMR_B_RCLK];
  wire sel_tx_a = t2ctl_q[`TMR_B_UART_A_TX_CLOCK_SELECT];
  wire sel_rx_b = pwrctl_q[`TMR_B_UART_B_RX_CLOCK_SELECT];                        // [RULE18]
  wire sel_tx_b = pwrctl_q[`TMR_B_UART_B_TX_CLOCK_SELECT];                        // [RULE18]
  wire baud     = sel_rx_a | sel_tx_a | sel_rx_b | sel_tx_b;     // [RULE12]
  wire t2_external_enable    = t2ctl_q[`TMR_B_T2_EXTERNAL_ENABLE];
  wire capture  = t2ctl_q[`TMR_B_CPRL2] && !baud;                // [RULE13]
  wire tick2    = t2ctl_q[`TMR_B_CT2] ? t2_edge : 1'b1;          // [RULE7]
  wire cnt2     = t2ctl_q[`TMR_B_TR2] && tick2;                  // [RULE19]
  wire [15:0] t2_full = {t2_high_byte_q, t2_low_byte_q};
  wire [15:0] cr_full = {capture_reload_high_q, capture_reload_low_q};
  wire ovf2     = cnt2 && t2_full == `TMR_FF16;
  wire ext_ev   = t2_external_enable && trig_edge;
  wire do_cap   = ext_ev && capture && !baud; // [RULE9] [RULE14]
  wire do_rld   = !capture &&                        // [RULE10] [RULE13]
                  (ovf2 || (ext_ev && !baud));       // [RULE11] [RULE14]

  logic [15:0] t2_d;
  always_comb begin
    t2_d = {wr_t2hi ? wdata_i : t2_high_byte_q,
            wr_t2lo ? wdata_i : t2_low_byte_q};
    if (do_rld) t2_d = cr_full;                                  // [RULE10]
    else if (cnt2) t2_d = t2_full + `TMR_ONE16;                  // [RULE8]
  end

  logic [15:0] cr_d;
  always_comb begin
    cr_d = {wr_crhi ? wdata_i : capture_reload_high_q,
            wr_crlo ? wdata_i : capture_reload_low_q};
    if (do_cap) cr_d = t2_full;                                  // [RULE9]
  end

  // hardware set wins over a software write in the same cycle
  tmr_byte_t t2ctl_d;
  always_comb begin
    t2ctl_d = wr_t2ctl ? wdata_i : t2ctl_q;                      // [RULE15]
    if (ovf2 && !baud) t2ctl_d[`TMR_B_TF2] = 1'b1; // [RULE8] [RULE12]
    if (ext_ev) t2ctl_d[`TMR_B_T2_EXTERNAL_FLAG] = 1'b1; // [RULE9] [RULE14]
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t2ctl_q               <= `TMR_RST8;                        // [RULE24]
      {t2_high_byte_q, t2_low_byte_q} <= {`TMR_RST8, `TMR_RST8};
      {capture_reload_high_q, capture_reload_low_q}
                            <= {`TMR_RST8, `TMR_RST8};
      t01ctl_q              <= `TMR_RST8;
      t01mode_q             <= `TMR_RST8;
      {t0_high_byte_q, t0_low_byte_q} <= {`TMR_RST8, `TMR_RST8};
      {t1_high_byte_q, t1_low_byte_q} <= {`TMR_RST8, `TMR_RST8};
      pwrctl_q              <= 2'h0;
    end else begin
      t2ctl_q               <= t2ctl_d;
      {t2_high_byte_q, t2_low_byte_q} <= t2_d;
      {capture_reload_high_q, capture_reload_low_q} <= cr_d;
      t01ctl_q              <= t01ctl_d;
      if (wr_t01md) t01mode_q <= wdata_i;
      t0_low_byte_q  <= wr_t0lo ? wdata_i : t0lo_d;
      t0_high_byte_q <= wr_t0hi ? wdata_i : t0hi_d;
      t1_low_byte_q  <= wr_t1lo ? wdata_i : t1lo_d;
      t1_high_byte_q <= wr_t1hi ? wdata_i : t1hi_d;
      if (wr_pwr) pwrctl_q <= wdata_i[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, zero elsewhere
  tmr_byte_t rd_mux;
  always_comb begin
    case (addr_i)
      `TMR_A_T2CTL:   rd_mux = t2ctl_q;
      `TMR_A_T2LO:    rd_mux = t2_low_byte_q;
      `TMR_A_T2HI:    rd_mux = t2_high_byte_q;
      `TMR_A_CRLO:    rd_mux = capture_reload_low_q;
      `TMR_A_CRHI:    rd_mux = capture_reload_high_q;
      `TMR_A_T01CTL:  rd_mux = t01ctl_q;
      `TMR_A_T01MODE: rd_mux = t01mode_q;
      `TMR_A_T0LO:    rd_mux = t0_low_byte_q;
      `TMR_A_T0HI:    rd_mux = t0_high_byte_q;
      `TMR_A_T1LO:    rd_mux = t1_low_byte_q;
      `TMR_A_T1HI:    rd_mux = t1_high_byte_q;
      `TMR_A_PWRCTL:  rd_mux = {6'h00, pwrctl_q};
      default:        rd_mux = `TMR_RST8;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) rdata_q <= `TMR_RST8;
    else       rdata_q <= rd_i ? rd_mux : `TMR_RST8;
  end
  assign rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign t0_irq_o = t01ctl_q[`TMR_B_TF0];
  assign t1_irq_o = t01ctl_q[`TMR_B_TF1];
  assign t2_irq_o = t2_irq_enable_i &&
                    (t2ctl_q[`TMR_B_TF2] || t2ctl_q[`TMR_B_T2_EXTERNAL_FLAG]); // [RULE20]
  // timer 1 overflow keeps clocking the uarts even when its flag is lent
  wire t2_bclk = cnt2 && t2_full == `TMR_FF16;
  assign uart_a_rx_clk_o = sel_rx_a ? t2_bclk : ovf1;            // [RULE16]
  assign uart_a_tx_clk_o = sel_tx_a ? t2_bclk : ovf1;            // [RULE17]
  assign uart_b_rx_clk_o = sel_rx_b ? t2_bclk : ovf1;            // [RULE18]
  assign uart_b_tx_clk_o = sel_tx_b ? t2_bclk : ovf1;            // [RULE18]

endmodule : tmr_timers
`default_nettype wire

// file: verif/tmr_timers_monitor.sv
// tmr_timers_monitor.sv: port-level assertions for tmr_timers
// assumes: bound to every tmr_timers instance by the line at the foot
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"
module tmr_timers_monitor
  import tmr_pkg::*;
(
  input wire logic      clk_i,
  input wire logic      rst_i,
  input wire tmr_addr_t addr_i,
  input wire tmr_byte_t wdata_i,
  input wire logic      wr_i,
  input wire logic      rd_i,
  input wire tmr_byte_t rdata_o,
  input wire logic      t2_irq_enable_i,
  input wire logic      t0_vector_ack_i,
  input wire logic      t1_vector_ack_i,
  input wire logic      t0_irq_o,
  input wire logic      t1_irq_o,
  input wire logic      t2_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic ctl_wr = wr_i && addr_i == `TMR_A_T2CTL;
  wire logic t01_wr = wr_i && addr_i == `TMR_A_T01CTL;
  wire logic irqs   = t0_irq_o | t1_irq_o | t2_irq_o;
  ////////////////////////////////////////////////////////////////////////////
  sequence s_rst_held;
    rst_i ##1 rst_i;
  endsequence
  sequence s_t2_soft_set;
    ctl_wr && wdata_i[`TMR_B_TF2] && t2_irq_enable_i ##1 t2_irq_enable_i;
  endsequence
  chk_reset_quiet: assert property (
    @(posedge clk_i) disable iff (1'b0)
    s_rst_held |-> !irqs && rdata_o == `TMR_RST8)
    else $error("outputs active while reset held");
  chk_irq_gated: assert property (t2_irq_o |-> t2_irq_enable_i)
    else $error("timer 2 interrupt without enable");
  chk_soft_flag: assert property (s_t2_soft_set |-> t2_irq_o)
    else $error("set timer 2 flag did not request interrupt");
  chk_t2_clear: assert property ($fell(t2_irq_o)
    && t2_irq_enable_i |-> $past(ctl_wr))
    else $error("timer 2 flag cleared without software write");
  chk_t0_set: assert property (t01_wr && wdata_i[`TMR_B_TF0]
    && !t0_vector_ack_i |=> t0_irq_o)
    else $error("timer 0 flag not set");
  chk_t0_clear: assert property ($fell(t0_irq_o)
    |-> $past(t0_vector_ack_i) || $past(t01_wr))
    else $error("timer 0 flag cleared without acknowledge");
  chk_t1_clear: assert property ($fell(t1_irq_o)
    |-> $past(t1_vector_ack_i) || $past(t01_wr))
    else $error("timer 1 flag cleared without acknowledge");
  chk_read_idle: assert property (!$past(rd_i) |-> rdata_o == `TMR_RST8)
    else $error("read data outside read answer cycle");
  chk_read_unmapped: assert property (rd_i && addr_i > `TMR_A_PWRCTL
    |=> rdata_o == `TMR_RST8)
    else $error("unmapped read returned data");
endmodule : tmr_timers_monitor
bind tmr_timers tmr_timers_monitor tmr_timers_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .t2_irq_enable_i(t2_irq_enable_i), .t0_vector_ack_i(t0_vector_ack_i),
  .t1_vector_ack_i(t1_vector_ack_i), .t0_irq_o(t0_irq_o),
  .t1_irq_o(t1_irq_o), .t2_irq_o(t2_irq_o));
`default_nettype wire

// file: verif/tmr_pins.sv
// tmr_pins.sv: model of the external gate, count and trigger pins
// assumes: requests arrive as one-cycle pulses on the system clock
`timescale 1ns/1ps
`default_nettype none
module tmr_pins (
  input  wire logic clk_i,
  input  wire logic trig_req_i,
  input  wire logic gate_low_i,
  output logic      gate_o,
  output logic      trig_o,
  output logic      count_o
);
  logic [2:0] low_q = 3'h0;
  // pulled-up pins idle high; low held 4 cycles so a 3-stage sync sees it
  always_ff @(posedge clk_i) begin
    if (trig_req_i) low_q <= 3'h4;
    else if (low_q != 3'h0) low_q <= low_q - 3'h1;
  end
  assign trig_o  = low_q == 3'h0;
  assign gate_o  = !gate_low_i;
  assign count_o = 1'b1;
endmodule : tmr_pins
`default_nettype wire

// file: verif/test_timer_modes_and_timer2.sv
// test_timer_modes_and_timer2.sv: self-checking bench for tmr_timers
// assumes: tmr_pins drives the pins, the monitor binds itself
`timescale 1ns/1ps
`default_nettype none
`include "tmr_params.svh"
module test_timer_modes_and_timer2 import tmr_pkg::*;;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic        ien = 1'b0, ack0 = 1'b0, ack1 = 1'b0, trig_req = 1'b0;
  logic        gate_low = 1'b0, rd_seen = 1'b0, gate, trig, cnt;
  logic        irq0, irq1, irq2, uclr = 1'b0;
  wire  [3:0]  uclk;
  tmr_addr_t   addr_i = 4'h0;
  tmr_byte_t   wdata_i = 8'h00, rdata_o;
  logic [15:0] ucnt = 16'h0000, rnd = 16'hA066, cr, e16;
  tmr_byte_t   exp_q[$];
  int          fails = 0, checks = 0;
  // timer 2 rows: control, power control, readback, count, uart pulses
  tmr_byte_t   t2c[8] = '{8'h04, 8'h05, 8'h14, 8'h25,
                          8'h04, 8'h04, 8'h06, 8'h00};
  tmr_byte_t   t2p[8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                          8'h02, 8'h01, 8'h00, 8'h00};
  tmr_byte_t   t2e[8] = '{8'h84, 8'h85, 8'h14, 8'h25,
                          8'h04, 8'h04, 8'h06, 8'h00};
  logic [15:0] t2r[8] = '{16'h0, 16'h2, 16'h0, 16'h0,
                          16'h0, 16'h0, 16'hFFFE, 16'hFFFE};
  logic [15:0] t2u[8] = '{16'h0, 16'h0, 16'h10, 16'h1,
                          16'h100, 16'h1000, 16'h0, 16'h0};
  tmr_byte_t   trc[5] = '{8'h09, 8'h08, 8'h18, 8'h01, 8'h80};
  tmr_byte_t   tre[5] = '{8'h49, 8'h48, 8'h58, 8'h01, 8'h80};
  // timer 0/1 rows: mode, run bits, status, high preset, low/high results
  tmr_byte_t   t0m[3] = '{8'h02, 8'h33, 8'h0A};
  tmr_byte_t   t0r[3] = '{8'h01, 8'h05, 8'h01};
  tmr_byte_t   t0e[3] = '{8'h03, 8'h0F, 8'h01};
  tmr_byte_t   t0h[3] = '{8'h5A, 8'hFE, 8'h5A};
  tmr_byte_t   t0l[3] = '{8'h5C, 8'h02, 8'hFE};
  tmr_byte_t   t0x[3] = '{8'h5A, 8'h02, 8'h5A};
  logic        t0g[3] = '{1'b0, 1'b0, 1'b1};

  tmr_timers tmr_timers_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .t0_external_gate_input_i(gate), .t1_external_gate_input_i(gate),
    .t0_count_input_i(cnt), .t1_count_input_i(cnt), .t2_count_input_i(cnt),
    .t2_trigger_input_i(trig), .t2_irq_enable_i(ien),
    .t0_vector_ack_i(ack0), .t1_vector_ack_i(ack1), .t0_irq_o(irq0),
    .t1_irq_o(irq1), .t2_irq_o(irq2), .uart_a_rx_clk_o(uclk[0]),
    .uart_a_tx_clk_o(uclk[1]), .uart_b_rx_clk_o(uclk[2]),
    .uart_b_tx_clk_o(uclk[3]));
  tmr_pins tmr_pins_inst (.clk_i(clk_i), .trig_req_i(trig_req),
    .gate_low_i(gate_low), .gate_o(gate), .trig_o(trig), .count_o(cnt));
  ////////////////////////////////////////////////////////////////////////////
  initial forever #2.5 clk_i = ~clk_i;

  function automatic logic [15:0] next(input logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    x ^= x << 8;
    return x;
  endfunction : next

  task automatic cmp(input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask : cmp

  task automatic conclude;
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  // one bus cycle; strobes stand exactly until the next call
  task automatic cyc(input logic w, r, input tmr_addr_t a, input tmr_byte_t d);
    @(posedge clk_i);
    wr_i    <= w;
    rd_i    <= r;
    addr_i  <= a;
    wdata_i <= d;
  endtask : cyc

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask : idle

  task automatic wr(input tmr_addr_t a, input tmr_byte_t d);
    cyc(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input tmr_addr_t a, input tmr_byte_t e);
    exp_q.push_back(e);
    cyc(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  task automatic wr16(input tmr_addr_t a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
  endtask : wr16

  task automatic rd16(input tmr_addr_t a, input logic [15:0] e);
    rd(a, e[7:0]);
    rd(a + 4'h1, e[15:8]);
  endtask : rd16

  // start, run four counting edges, read status mid-run, then stop
  task automatic run(input tmr_addr_t a, input tmr_byte_t go, stop, e);
    uclr <= 1'b1;
    wr(a, go);
    uclr <= 1'b0;
    idle(2);
    rd(a, e);
    wr(a, stop);
    idle(1);
  endtask : run

  always @(posedge clk_i) begin
    if (rd_seen) cmp({8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
    rd_seen <= rd_i;
    // pulse counters are cleared here only, so ucnt has one driver
    for (int i = 0; i < 4; i++)
      if (uclr) ucnt[i*4 +: 4] <= 4'h0;
      else if (uclk[i] === 1'b1) ucnt[i*4 +: 4] <= ucnt[i*4 +: 4] + 4'h1;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    ien   <= 1'b1;
    idle(3);
    wr(4'hC, 8'hFF);
    for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
    rnd = next(rnd);
    cr  = rnd & 16'h7FFF;
    wr16(`TMR_A_CRLO, cr);
    for (int i = 0; i < 8; i++) begin
      wr(`TMR_A_PWRCTL, t2p[i]);
      wr16(`TMR_A_T2LO, 16'hFFFE);
      run(`TMR_A_T2CTL, t2c[i], 8'h00, t2e[i]);
      e16 = (t2r[i] == 16'h0000) ? cr + 16'h0002 : t2r[i];
      rd16(`TMR_A_T2LO, e16);
      cmp(ucnt, t2u[i]);
    end
    for (int i = 0; i < 5; i++) begin
      // third pass runs with the interrupt masked
      ien <= (i != 2);
      rnd = next(rnd);
      wr16(`TMR_A_CRLO, cr);
      wr16(`TMR_A_T2LO, rnd);
      wr(`TMR_A_T2CTL, trc[i]);
      trig_req <= 1'b1;
      idle(1);
      trig_req <= 1'b0;
      idle(8);
      cmp({15'h0, irq2}, {15'h0, i != 2 && |tre[i][7:6]});
      rd(`TMR_A_T2CTL, tre[i]);
      rd16(`TMR_A_T2LO, (trc[i] == 8'h08) ? cr : rnd);
      rd16(`TMR_A_CRLO, (trc[i] == 8'h09) ? rnd : cr);
      wr(`TMR_A_T2CTL, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      gate_low <= t0g[i];
      wr(`TMR_A_T01MODE, t0m[i]);
      wr(`TMR_A_T0LO, 8'hFE);
      wr(`TMR_A_T0HI, t0h[i]);
      wr(`TMR_A_T1LO, 8'h10);
      run(`TMR_A_T01CTL, t0r[i], t0e[i] & 8'h0A, t0e[i]);
      rd(`TMR_A_T0LO, t0l[i]);
      rd(`TMR_A_T0HI, t0x[i]);
      rd(`TMR_A_T1LO, 8'h10);
      cmp({14'h0, irq1, irq0}, {14'h0, t0e[i][3], t0e[i][1]});
      ack0 <= 1'b1;
      ack1 <= 1'b1;
      idle(1);
      ack0 <= 1'b0;
      ack1 <= 1'b0;
      rd(`TMR_A_T01CTL, 8'h00);
    end
    idle(3);
    conclude();
  end
endmodule : test_timer_modes_and_timer2
`default_nettype wire
